/* hdl/cal_pkg.sv */
// Constants for the converter calibration sequencer.
// Assumes a 25 MHz clock that is also the converter master clock.
// Contract
// - Mode code 001 starts full self-calibration: zero step, then full step.
// - Self zero step shorts the pair to bias, converts at selected gain.
// - Self full step converts reference over gain, at selected gain.
// - Full self-cal takes six periods, three per step; mode then reads 000.
// - Ready flag goes high at any start; low nine periods after full self.
// - Ready flag rises within one modulator cycle; host ignores it that long.
// - Bipolar self-cal uses same points; zero input gives 800000 hex.
// - Code 110 runs only zero step, code 111 only full step.
// - Single self step: mode clears after three periods, ready low after six.
// - A later single step updates only its own coefficient.
// - Code 010 starts zero system step on the external input.
// - Zero system step: mode clears after three periods, ready after four.
// - Code 011 starts full system step on the external input.
// - Full system step: mode clears after three periods, ready after four.
// - Conversion after a system step lands in the data register.
// - Unipolar maps both endpoints; bipolar maps midscale to plus full scale.
// - Offset is subtracted before the gain coefficient multiplies.
package cal_pkg;
  // Wishbone byte offsets
  localparam logic [7:0]  ADDR_MODE   = 8'h00;
  localparam logic [7:0]  ADDR_FILTER = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_ZERO   = 8'h0C;
  localparam logic [7:0]  ADDR_GAIN   = 8'h10;
  localparam logic [7:0]  ADDR_DATA   = 8'h14;
  // Mode register fields
  localparam int          MODE_LSB    = 0;
  localparam int          GAIN_LSB    = 3;
  localparam int          BIPOLAR_BIT = 6;
  // Calibration mode codes
  localparam logic [2:0]  MODE_NORMAL    = 3'h0;
  localparam logic [2:0]  MODE_SELF      = 3'h1;
  localparam logic [2:0]  MODE_SYS_ZERO  = 3'h2;
  localparam logic [2:0]  MODE_SYS_FULL  = 3'h3;
  localparam logic [2:0]  MODE_SELF_ZERO = 3'h6;
  localparam logic [2:0]  MODE_SELF_FULL = 3'h7;
  // Reset values and the filter word floor
  localparam logic [11:0] FILTER_RST  = 12'h080;
  localparam logic [11:0] FILTER_MIN  = 12'h001;
  localparam logic [23:0] ZERO_RST    = 24'h000000;
  localparam logic [23:0] GAIN_RST    = 24'h400000;
  // Timing: modulator cycle in clocks, step and conversion lengths in output-word periods
  localparam int          MOD_CLOCKS  = 128;
  localparam int          MOD_SHIFT   = 7;
  localparam logic [1:0]  STEP_PERIODS      = 2'h3;
  localparam logic [1:0]  SELF_CONV_PERIODS = 2'h3;
  localparam logic [1:0]  SYS_CONV_PERIODS  = 2'h1;
  // Coefficient arithmetic
  localparam int          GAIN_FRAC   = 22;
  localparam logic [5:0]  DIV_STEPS   = 6'h2E;
  localparam logic [23:0] FS_UNI      = 24'hFFFFFF;
  localparam logic [23:0] FS_BI       = 24'h7FFFFF;
  localparam logic [23:0] MIDSCALE    = 24'h800000;
  // Front end source
  typedef enum logic [1:0] {SRC_EXT, SRC_BIAS, SRC_REF} source_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ZERO, ST_FULL, ST_CONV} calState_t;
endpackage : cal_pkg

/* hdl/cal_if.sv */
// Carrier between the sequencer, its period timer and its corrector.
// Assumes all three run on the same clock.
`timescale 1ns/1ns
interface cal_if;
  logic        timerRestart;
  logic [11:0] filterWord;
  logic        periodTick;
  logic [23:0] rawWord;
  logic [23:0] zeroCoef;
  logic [23:0] gainCoef;
  logic        bipolar;
  logic [23:0] corrected;
  logic        divStart;
  logic [23:0] span;
  logic [23:0] target;
  logic        divDone;
  logic [23:0] divQuot;
  modport timer (input timerRestart, input filterWord, output periodTick);
  modport corr (input rawWord, input zeroCoef, input gainCoef, input bipolar,
                input divStart, input span, input target,
                output corrected, output divDone, output divQuot);
endinterface : cal_if

/* hdl/period_timer.sv */
// Output-word period timer: one tick every 128 times filter word clocks.
// Assumes the filter word is never zero.
`timescale 1ns/1ns
module period_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Sequencer side
  cal_if.timer     tb
);
  logic [18:0] count_r;
  logic        tick_r;
  logic [18:0] lastCount;

  assign lastCount = {tb.filterWord, 7'h00} - 19'h00001;
  assign tb.periodTick = tick_r;

  // Restart aligns period edges to the command write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 19'h00000;
      tick_r  <= 1'b0;
    end else if (tb.timerRestart) begin
      count_r <= 19'h00000;
      tick_r  <= 1'b0;
    end else if (count_r >= lastCount) begin
      count_r <= 19'h00000;
      tick_r  <= 1'b1;
    end else begin
      count_r <= count_r + 19'h00001;
      tick_r  <= 1'b0;
    end
  end
endmodule : period_timer

/* hdl/coeff_corrector.sv */
// Applies offset and gain coefficients; derives the gain by division.
// Assumes span is held steady from divStart until divDone.
`timescale 1ns/1ns
module coeff_corrector (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Sequencer side
  cal_if.corr      cb
);
  logic signed [24:0] diff;
  logic signed [49:0] prod;
  logic signed [49:0] shifted;
  logic [23:0]        mid;
  logic [45:0]        dvd_r;
  logic [45:0]        quot_r;
  logic [23:0]        rem_r;
  logic [23:0]        dvs_r;
  logic [5:0]         cnt_r;
  logic               busy_r;
  logic               done_r;
  logic [24:0]        trial;
  logic [24:0]        less;

  // Offset first, so the gain term scales span only
  assign diff = $signed({1'b0, cb.rawWord}) - $signed({1'b0, cb.zeroCoef});
  assign prod = diff * $signed({1'b0, cb.gainCoef});
  assign mid = cb.bipolar ? cal_pkg::MIDSCALE : 24'h000000;
  assign shifted = (prod >>> cal_pkg::GAIN_FRAC) + $signed({26'h0000000, mid});

  always_comb begin
    if (shifted < 50'sh0) begin
      cb.corrected = 24'h000000;
    end else if (shifted > 50'shFFFFFF) begin
      cb.corrected = 24'hFFFFFF;
    end else begin
      cb.corrected = shifted[23:0];
    end
  end

  // Restoring divider: target scaled by 2^22 over span
  assign trial = {rem_r, dvd_r[45]};
  assign less = trial - {1'b0, dvs_r};
  assign cb.divDone = done_r;
  assign cb.divQuot = (quot_r[45:24] != 22'h000000) ? 24'hFFFFFF : quot_r[23:0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dvd_r  <= 46'h0;
      quot_r <= 46'h0;
      rem_r  <= 24'h000000;
      dvs_r  <= 24'h000000;
      cnt_r  <= 6'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else if (cb.divStart) begin
      dvd_r  <= {cb.target, 22'h000000};
      quot_r <= 46'h0;
      rem_r  <= 24'h000000;
      dvs_r  <= cb.span;
      cnt_r  <= cal_pkg::DIV_STEPS;
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end else if (busy_r) begin
      dvd_r <= {dvd_r[44:0], 1'b0};
      if (trial >= {1'b0, dvs_r}) begin
        rem_r  <= less[23:0];
        quot_r <= {quot_r[44:0], 1'b1};
      end else begin
        rem_r  <= trial[23:0];
        quot_r <= {quot_r[44:0], 1'b0};
      end
      cnt_r  <= cnt_r - 6'h01;
      busy_r <= (cnt_r != 6'h01);
      done_r <= (cnt_r == 6'h01);
    end else begin
      done_r <= 1'b0;
    end
  end
endmodule : coeff_corrector

/* hdl/adc_calibration_sequencer.sv */
// Calibration sequencer top: Wishbone registers, step sequencing,
// ready flag and front end source and gain select.
// Assumes filter words arrive on rawWord/rawValid in the clock domain.
`timescale 1ns/1ns
module adc_calibration_sequencer (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Filter output words
  input  wire logic        rawValid,
  input  wire logic [23:0] rawWord,
  // Front end control
  output cal_pkg::source_t inputSel,
  output logic [2:0]       gainSel,
  // Ready flag to host
  output logic             result_ready_n
);
  cal_if bus ();

  cal_pkg::calState_t state_r;
  cal_pkg::source_t   src_r;
  logic [2:0]         mode_r;
  logic [2:0]         gain_r;
  logic               bipolar_r;
  logic [11:0]        filter_r;
  logic [23:0]        zero_r;
  logic [23:0]        gainCoef_r;
  logic [23:0]        data_r;
  logic [23:0]        lastRaw_r;
  logic [23:0]        span_r;
  logic [1:0]         periods_r;
  logic [1:0]         convLen_r;
  logic               divStart_r;
  logic               ack_r;
  logic [31:0]        rdData_r;
  logic               ready_n_r;

  logic               access;
  logic               wbWrite;
  logic               wbRead;
  logic               idle;
  logic               modeWrite;
  logic               calStart;
  logic               tick;
  logic               stepEnd;
  logic               convEnd;
  logic               newWord;
  logic               dataRead;
  logic [2:0]         code;
  logic [31:0]        wrFilter;
  logic [31:0]        wrZero;
  logic [31:0]        wrGain;

  function automatic logic isCal(input logic [2:0] c);
    isCal = (c == cal_pkg::MODE_SELF) | (c == cal_pkg::MODE_SELF_ZERO) |
            (c == cal_pkg::MODE_SELF_FULL) | (c == cal_pkg::MODE_SYS_ZERO) |
            (c == cal_pkg::MODE_SYS_FULL);
  endfunction : isCal

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction : merge

  // Bus decode; one request per ack
  assign access    = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wbWrite   = access & wb_we_i;
  assign wbRead    = access & ~wb_we_i;
  assign idle      = (state_r == cal_pkg::ST_IDLE);
  assign code      = wb_dat_i[cal_pkg::MODE_LSB +: 3];
  assign modeWrite = wbWrite & (wb_adr_i == cal_pkg::ADDR_MODE) & wb_sel_i[0];
  assign calStart  = modeWrite & isCal(code);
  assign dataRead  = wbRead & (wb_adr_i == cal_pkg::ADDR_DATA);
  assign wrFilter  = merge({20'h00000, filter_r}, wb_dat_i, wb_sel_i);
  assign wrZero    = merge({8'h00, zero_r}, wb_dat_i, wb_sel_i);
  assign wrGain    = merge({8'h00, gainCoef_r}, wb_dat_i, wb_sel_i);

  // Period bookkeeping
  assign tick    = bus.periodTick;
  assign stepEnd = tick & ((periods_r + 2'h1) == cal_pkg::STEP_PERIODS);
  assign convEnd = tick & ((periods_r + 2'h1) == convLen_r);
  assign newWord = tick & (idle | ((state_r == cal_pkg::ST_CONV) & convEnd));

  // Timer restarts on the command edge itself
  assign bus.timerRestart = calStart;
  assign bus.filterWord   = filter_r;
  assign bus.rawWord      = lastRaw_r;
  assign bus.zeroCoef     = zero_r;
  assign bus.gainCoef     = gainCoef_r;
  assign bus.bipolar      = bipolar_r;
  assign bus.divStart     = divStart_r;
  assign bus.span         = span_r;
  assign bus.target       = bipolar_r ? cal_pkg::FS_BI : cal_pkg::FS_UNI;

  period_timer uTimer (
    .clock (clock),
    .rst_n (rst_n),
    .tb    (bus.timer)
  );

  coeff_corrector uCorr (
    .clock (clock),
    .rst_n (rst_n),
    .cb    (bus.corr)
  );

  // Step sequencing; a new command restarts from any state
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= cal_pkg::ST_IDLE;
    end else if (calStart) begin
      case (code)
        cal_pkg::MODE_SELF:      state_r <= cal_pkg::ST_ZERO;
        cal_pkg::MODE_SELF_ZERO: state_r <= cal_pkg::ST_ZERO;
        cal_pkg::MODE_SYS_ZERO:  state_r <= cal_pkg::ST_ZERO;
        default:                 state_r <= cal_pkg::ST_FULL;
      endcase
    end else begin
      case (state_r)
        cal_pkg::ST_IDLE: state_r <= cal_pkg::ST_IDLE;
        cal_pkg::ST_ZERO: begin
          if (stepEnd) begin
            state_r <= (mode_r == cal_pkg::MODE_SELF) ? cal_pkg::ST_FULL
                                                       : cal_pkg::ST_CONV;
          end
        end
        cal_pkg::ST_FULL: begin
          if (stepEnd) begin
            state_r <= cal_pkg::ST_CONV;
          end
        end
        cal_pkg::ST_CONV: begin
          if (convEnd) begin
            state_r <= cal_pkg::ST_IDLE;
          end
        end
        default: state_r <= cal_pkg::ST_IDLE;
      endcase
    end
  end

  // Periods elapsed within the current step
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      periods_r <= 2'h0;
    end else if (calStart || idle) begin
      periods_r <= 2'h0;
    end else if (stepEnd && (state_r != cal_pkg::ST_CONV)) begin
      periods_r <= 2'h0;
    end else if (tick) begin
      periods_r <= periods_r + 2'h1;
    end
  end

  // Trailing input conversion length
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      convLen_r <= cal_pkg::SELF_CONV_PERIODS;
    end else if (calStart) begin
      if ((code == cal_pkg::MODE_SYS_ZERO) || (code == cal_pkg::MODE_SYS_FULL)) begin
        convLen_r <= cal_pkg::SYS_CONV_PERIODS;
      end else begin
        convLen_r <= cal_pkg::SELF_CONV_PERIODS;
      end
    end
  end

  // Mode field, gain and polarity; field clears when the steps finish
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r    <= cal_pkg::MODE_NORMAL;
      gain_r    <= 3'h0;
      bipolar_r <= 1'b0;
    end else if (modeWrite) begin
      mode_r    <= isCal(code) ? code : cal_pkg::MODE_NORMAL;
      gain_r    <= wb_dat_i[cal_pkg::GAIN_LSB +: 3];
      bipolar_r <= wb_dat_i[cal_pkg::BIPOLAR_BIT];
    end else if (stepEnd && (state_r == cal_pkg::ST_ZERO)
                 && (mode_r != cal_pkg::MODE_SELF)) begin
      mode_r <= cal_pkg::MODE_NORMAL;
    end else if (stepEnd && (state_r == cal_pkg::ST_FULL)) begin
      mode_r <= cal_pkg::MODE_NORMAL;
    end
  end

  // Front end source per step
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_r <= cal_pkg::SRC_EXT;
    end else if (calStart) begin
      case (code)
        cal_pkg::MODE_SELF:      src_r <= cal_pkg::SRC_BIAS;
        cal_pkg::MODE_SELF_ZERO: src_r <= cal_pkg::SRC_BIAS;
        cal_pkg::MODE_SELF_FULL: src_r <= cal_pkg::SRC_REF;
        default:                 src_r <= cal_pkg::SRC_EXT;
      endcase
    end else if (stepEnd && (state_r == cal_pkg::ST_ZERO)
                 && (mode_r == cal_pkg::MODE_SELF)) begin
      src_r <= cal_pkg::SRC_REF;
    end else if (stepEnd) begin
      src_r <= cal_pkg::SRC_EXT;
    end
  end

  // Latest filter word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lastRaw_r <= 24'h000000;
    end else if (rawValid) begin
      lastRaw_r <= rawWord;
    end
  end

  // Filter word; zero would stretch the period timer to 2^19 clocks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      filter_r <= cal_pkg::FILTER_RST;
    end else if (wbWrite && (wb_adr_i == cal_pkg::ADDR_FILTER)) begin
      filter_r <= (wrFilter[11:0] == 12'h000) ? cal_pkg::FILTER_MIN : wrFilter[11:0];
    end
  end

  // Offset coefficient: only the zero step or software touches it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      zero_r <= cal_pkg::ZERO_RST;
    end else if (stepEnd && (state_r == cal_pkg::ST_ZERO)) begin
      zero_r <= lastRaw_r;
    end else if (idle && wbWrite && (wb_adr_i == cal_pkg::ADDR_ZERO)) begin
      zero_r <= wrZero[23:0];
    end
  end

  // Gain derivation starts at the end of the full step
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      divStart_r <= 1'b0;
      span_r     <= 24'h000000;
    end else begin
      divStart_r <= stepEnd && (state_r == cal_pkg::ST_FULL);
      if (stepEnd && (state_r == cal_pkg::ST_FULL)) begin
        span_r <= lastRaw_r - zero_r;
      end
    end
  end

  // Gain coefficient: only the full step or software touches it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gainCoef_r <= cal_pkg::GAIN_RST;
    end else if (bus.divDone) begin
      gainCoef_r <= bus.divQuot;
    end else if (idle && wbWrite && (wb_adr_i == cal_pkg::ADDR_GAIN)) begin
      gainCoef_r <= wrGain[23:0];
    end
  end

  // Corrected result lands at each new word
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= 24'h000000;
    end else if (newWord) begin
      data_r <= bus.corrected;
    end
  end

  // Ready flag: a start wins, a new word beats a read in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_n_r <= 1'b1;
    end else if (calStart) begin
      ready_n_r <= 1'b1;
    end else if (newWord) begin
      ready_n_r <= 1'b0;
    end else if (dataRead) begin
      ready_n_r <= 1'b1;
    end
  end

  // Bus answer one cycle after the request
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r    <= 1'b0;
      rdData_r <= 32'h00000000;
    end else begin
      ack_r <= access;
      if (wbRead) begin
        case (wb_adr_i)
          cal_pkg::ADDR_MODE:   rdData_r <= {25'h0000000, bipolar_r, gain_r, mode_r};
          cal_pkg::ADDR_FILTER: rdData_r <= {20'h00000, filter_r};
          cal_pkg::ADDR_STATUS: rdData_r <= {28'h0000000, periods_r, ~idle, ready_n_r};
          cal_pkg::ADDR_ZERO:   rdData_r <= {8'h00, zero_r};
          cal_pkg::ADDR_GAIN:   rdData_r <= {8'h00, gainCoef_r};
          cal_pkg::ADDR_DATA:   rdData_r <= {8'h00, data_r};
          default:              rdData_r <= 32'h00000000;
        endcase
      end
    end
  end

  assign wb_dat_o       = rdData_r;
  assign wb_ack_o       = ack_r;
  assign inputSel       = src_r;
  assign gainSel        = gain_r;
  assign result_ready_n = ready_n_r;
endmodule : adc_calibration_sequencer

/* testbench/cal_seq_sva.sv */
// Port checker for the calibration sequencer.
// Assumes FILTER holds 1, so one output period is PERIOD clocks.
`timescale 1ns/1ns
module cal_seq_sva #(parameter int PERIOD = 128) (
  // Clock and reset
  input wire logic             clock,
  input wire logic             rst_n,
  // Wishbone
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic             wb_we_i,
  input wire logic [7:0]       wb_adr_i,
  input wire logic [3:0]       wb_sel_i,
  input wire logic [31:0]      wb_dat_i,
  input wire logic             wb_ack_o,
  // Front end and flag
  input wire cal_pkg::source_t inputSel,
  input wire logic [2:0]       gainSel,
  input wire logic             result_ready_n
);
  logic        calStart;
  logic [2:0]  code;
  logic [2:0]  lastMode_r;
  logic        pend_r;
  logic [11:0] cnt_r;
  logic [11:0] expRdy;
  assign code = wb_dat_i[2:0];
  assign calStart = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
    && wb_adr_i == cal_pkg::ADDR_MODE && code inside {3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
  // Flag registers on the tick edge, so the fall is seen one edge later
  assign expRdy = (lastMode_r == cal_pkg::MODE_SELF) ? 12'(9 * PERIOD + 2) :
                  lastMode_r[2] ? 12'(6 * PERIOD + 2) : 12'(4 * PERIOD + 2);
  // Saturating count of cycles since the last command
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 12'hFFF;
      lastMode_r <= 3'h0;
    end else if (calStart) begin
      cnt_r <= 12'h001;
      lastMode_r <= code;
    end else if (cnt_r != 12'hFFF) begin
      cnt_r <= cnt_r + 12'h001;
    end
  end
  // Only the first fall after a command is timed
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) pend_r <= 1'b0;
    else if (calStart) pend_r <= 1'b1;
    else if (!result_ready_n) pend_r <= 1'b0;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ackOnce; wb_ack_o ##1 !wb_ack_o; endsequence
  property p_ackPulse; s_taken |=> s_ackOnce; endproperty
  a_ackPulse: assert property (p_ackPulse) else $error("ack is not one pulse");
  property p_readyRise; calStart |=> result_ready_n; endproperty
  a_readyRise: assert property (p_readyRise) else $error("ready flag not raised");
  property p_zeroSrc; calStart && code inside {3'h1, 3'h6} |=> inputSel == cal_pkg::SRC_BIAS;
  endproperty
  a_zeroSrc: assert property (p_zeroSrc) else $error("zero step source");
  property p_fullSrc; calStart && code == 3'h7 |=> inputSel == cal_pkg::SRC_REF; endproperty
  a_fullSrc: assert property (p_fullSrc) else $error("full step source");
  property p_sysSrc; calStart && code[2:1] == 2'h1 |=> inputSel == cal_pkg::SRC_EXT;
  endproperty
  a_sysSrc: assert property (p_sysSrc) else $error("system step source");
  property p_gainSel; calStart |=> gainSel == $past(wb_dat_i[5:3]); endproperty
  a_gainSel: assert property (p_gainSel) else $error("gain select");
  property p_selfSwap;
    lastMode_r == 3'h1 && cnt_r == 12'(3 * PERIOD + 2) |-> inputSel == cal_pkg::SRC_REF;
  endproperty
  a_selfSwap: assert property (p_selfSwap) else $error("self swap time");
  property p_selfEnd;
    lastMode_r == 3'h1 && cnt_r == 12'(6 * PERIOD + 2) |-> inputSel == cal_pkg::SRC_EXT;
  endproperty
  a_selfEnd: assert property (p_selfEnd) else $error("self end time");
  property p_readyTime; pend_r && $fell(result_ready_n) |-> cnt_r == expRdy; endproperty
  a_readyTime: assert property (p_readyTime) else $error("ready time");
endmodule : cal_seq_sva

/* testbench/front_end_model.sv */
// Stand-in for front end and filter: one word every 8 clocks.
// Assumes the bench sets the three source levels.
`timescale 1ns/1ns
module front_end_model (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Source select and levels
  input  wire cal_pkg::source_t inputSel,
  input  wire logic [23:0]      biasLevel,
  input  wire logic [23:0]      refLevel,
  input  wire logic [23:0]      extLevel,
  // Filter words
  output logic                  rawValid,
  output logic [23:0]           rawWord
);
  logic [2:0]  div_r;
  logic [23:0] word;
  assign word = (inputSel == cal_pkg::SRC_BIAS) ? biasLevel :
                (inputSel == cal_pkg::SRC_REF) ? refLevel : extLevel;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 3'h0;
      rawValid <= 1'b0;
      rawWord <= 24'h000000;
    end else begin
      div_r <= div_r + 3'h1;
      rawValid <= (div_r == 3'h7);
      // Inverted between words so a stale sample shows
      rawWord <= (div_r == 3'h7) ? word : ~word;
    end
  end
endmodule : front_end_model

/* testbench/tb_top.sv */
// Self-checking bench for the calibration sequencer.
// Assumes FILTER is set to 1, giving a 128-clock output period.
`timescale 1ns/1ns
module tb_top;
  localparam int P = 128;
  typedef struct {logic [7:0] adr; logic [31:0] exp;} regRow_t;
  typedef struct {logic [2:0] code; logic bip; logic [23:0] bias, refl, ext, zero, gain, data;
                  int clr, rdy;} calRow_t;
  logic clock = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, rawValid, result_ready_n;
  logic [23:0] rawWord, bias = 24'h0, refl = 24'h0, ext = 24'h0;
  logic [2:0]  gainSel;
  cal_pkg::source_t inputSel;
  int errors = 0, tests_run = 0, cyc = 0, t0, n;
  regRow_t rr[8] = '{'{cal_pkg::ADDR_MODE, 32'h0}, '{cal_pkg::ADDR_FILTER, 32'h80},
    '{cal_pkg::ADDR_ZERO, 32'h0}, '{cal_pkg::ADDR_GAIN, 32'h400000},
    '{cal_pkg::ADDR_DATA, 32'h0}, '{8'h18, 32'h0}, '{8'h1C, 32'h0},
    '{cal_pkg::ADDR_STATUS, 32'h1}};
  calRow_t cr[6] = '{
    '{cal_pkg::MODE_SELF, 0, 24'h100, 24'h800100, 24'h200100, 24'h100, 24'h7FFFFF, 24'h3FFFFF, 6, 9},
    '{cal_pkg::MODE_SELF_ZERO, 0, 24'h200, 24'h800100, 24'h200, 24'h200, 24'h7FFFFF, 24'h0, 3, 6},
    '{cal_pkg::MODE_SELF_FULL, 0, 24'h200, 24'h400200, 24'h400200, 24'h200, 24'hFFFFFF, 24'hFFFFFF, 3, 6},
    '{cal_pkg::MODE_SYS_ZERO, 0, 24'h200, 24'h400200, 24'h1000, 24'h1000, 24'hFFFFFF, 24'h0, 3, 4},
    '{cal_pkg::MODE_SYS_FULL, 0, 24'h200, 24'h400200, 24'h401000, 24'h1000, 24'hFFFFFF, 24'hFFFFFF, 3, 4},
    '{cal_pkg::MODE_SELF, 1, 24'h100, 24'h400100, 24'h100, 24'h100, 24'h7FFFFF, 24'h800000, 6, 9}};
  adc_calibration_sequencer dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rawValid(rawValid),
    .rawWord(rawWord), .inputSel(inputSel), .gainSel(gainSel), .result_ready_n(result_ready_n));
  front_end_model fe (.clock(clock), .rst_n(rst_n), .inputSel(inputSel), .biasLevel(bias),
    .refLevel(refl), .extLevel(ext), .rawValid(rawValid), .rawWord(rawWord));
  initial begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One classic cycle; the answer is taken at the ack edge only
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin @(posedge clock); k++; end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin errors++; complete_run(); end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rr[i]) begin
      bus(0, rr[i].adr, 32'h0);
      check(q, rr[i].exp);
    end
    bus(1, 8'h18, 32'h1234);
    bus(0, 8'h18, 32'h0);
    check(q, 32'h0);
    bus(1, cal_pkg::ADDR_FILTER, 32'h0);
    bus(0, cal_pkg::ADDR_FILTER, 32'h0);
    check(q, 32'h1);
    bus(1, cal_pkg::ADDR_FILTER, 32'h1);
    // Host orders full steps after zero steps and holds levels
    foreach (cr[i]) begin
      bias <= cr[i].bias;
      refl <= cr[i].refl;
      ext <= cr[i].ext;
      bus(1, cal_pkg::ADDR_MODE, {25'h0, cr[i].bip, 3'h2, cr[i].code});
      t0 = cyc;
      n = 0;
      do begin bus(0, cal_pkg::ADDR_MODE, 32'h0); n++; end while (q[2:0] !== 3'h0 && n < 900);
      if (n >= 900) begin errors++; complete_run(); end
      n = cyc - t0 - cr[i].clr * P;
      check(32'(n >= -3 && n <= 3), 32'h1);
      n = 0;
      while (result_ready_n !== 1'b0 && n < 2000) begin @(posedge clock); n++; end
      if (n >= 2000) begin errors++; complete_run(); end
      // t0 is the ack edge; the flag falls on the tick edge and is seen one later
      check(cyc - t0, cr[i].rdy * P + 1);
      bus(0, cal_pkg::ADDR_ZERO, 32'h0);
      check(q, {8'h0, cr[i].zero});
      bus(0, cal_pkg::ADDR_GAIN, 32'h0);
      check(q, {8'h0, cr[i].gain});
      bus(0, cal_pkg::ADDR_DATA, 32'h0);
      check(q, {8'h0, cr[i].data});
      @(posedge clock);
      check({31'h0, result_ready_n}, 32'h1);
    end
    // Unsupported codes must not start anything
    bus(1, cal_pkg::ADDR_MODE, 32'h4);
    bus(0, cal_pkg::ADDR_MODE, 32'h0);
    check({29'h0, q[2:0]}, 32'h0);
    // Reset in mid-calibration returns to idle at once
    bus(1, cal_pkg::ADDR_MODE, 32'h1);
    rst_n <= 1'b0;
    @(posedge clock);
    check({29'h0, inputSel, result_ready_n}, 32'h1);
    rst_n <= 1'b1;
    bus(0, cal_pkg::ADDR_MODE, 32'h0);
    check(q, 32'h0);
    complete_run();
  end
endmodule : tb_top
bind adc_calibration_sequencer cal_seq_sva #(.PERIOD(128)) chk (.clock, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .inputSel, .gainSel,
  .result_ready_n);
